// ==== rtl/dbs_burst_sram.sv ====
`timescale 1ns/1ps
// ************************************************************************
// Dual-port burst-of-four SRAM core with split read and write ports.
// ************************************************************************
module dbs_burst_sram (
	input logic clk,
	input logic reset_n,
	input logic clkEn,
	input logic outStrobeClk,
	input logic readPortSelectN,
	input logic writePortSelectN,
	input logic [dbs_pkg::ADDR_W-1:0] address,
	input logic [dbs_pkg::WORD_W-1:0] writeBusIn,
	input logic [dbs_pkg::LANES-1:0] laneWriteEnableN,
	input logic outClockRiseLevel,
	input logic outClockFallLevel,
	input logic dllOffN,
	input logic [dbs_pkg::IMP_W-1:0] impedanceRefPin,
	output logic [dbs_pkg::WORD_W-1:0] readBusOut,
	output logic readBusOe,
	output logic echoStrobeRise,
	output logic echoStrobeFall,
	output logic singleClockMode,
	output logic dllLocked,
	output logic [dbs_pkg::IMP_W-1:0] impedanceCode,
	output logic impedanceUpdate
);
	localparam int AW = dbs_pkg::ADDR_W; // Local copy for size casts.
	localparam int LW = dbs_pkg::LANE_W; // Local copy for lane slicing.

	// Address of word idx of a burst; wraps at the top of the array.
	function automatic logic [AW-1:0] wordAddr(input logic [AW-1:0] base, input int idx);
		return base + AW'(idx);
	endfunction

	// ********************************************************************
	// Storage and state.
	// ********************************************************************
	logic [dbs_pkg::WORD_W-1:0] mem [dbs_pkg::DEPTH]; // The array itself.
	logic kEdge_q; // High when the coming edge is a rising input-clock edge.
	dbs_pkg::dbs_start_type lastStart_q; // Start seen at the last rising edge.
	logic startRead; // A read starts at this edge.
	logic startWrite; // A write starts at this edge.
	logic [2:0] rdCnt_q; // Edges since the read started; zero when idle.
	logic [AW-1:0] rdAddr_q; // Captured read base address.
	logic rdHand; // Read burst is handed to the output this edge.
	dbs_pkg::dbs_burst_type rdMerged; // Array words with write forwarding.
	logic wrArm1_q; // Write accepted one edge ago.
	logic wrArm2_q; // Write accepted two edges ago; word 0 is due.
	logic [AW-1:0] wrPendAddr_q; // Address of the accepted write.
	logic [AW-1:0] colAddr_q; // Address of the burst being collected.
	logic [1:0] colCnt_q; // Next word slot while collecting.
	logic wrCommit_q; // Collected burst is written at this edge.
	dbs_pkg::dbs_lane_word_type wrBuf_q [dbs_pkg::BURST]; // Collected words.
	dbs_pkg::dbs_lane_word_type inWord; // Word on the write pins now.
	dbs_pkg::dbs_burst_type xBurst_q; // Burst held for the output domain.
	logic xTog_q; // Flips once per burst handed across.
	logic [2:0][1:0] strapSync_q; // Output clock pin levels, synchroniser.
	logic strapDone_q; // Strap already taken.
	logic [2:0] dOffSync_q; // Loop disable pin synchroniser.
	logic dllOn_q; // Filtered loop enable level.
	logic [2:0][dbs_pkg::IMP_W-1:0] impSync_q; // Impedance code synchroniser.
	logic [dbs_pkg::CNT_W-1:0] impCnt_q; // Cadence counter.
	logic [dbs_pkg::CNT_W-1:0] lockCnt_q; // Stable clock count.
	logic [dbs_pkg::CNT_W-1:0] stopCnt_q; // Cycles the input clock stood.
	logic [2:0] linkRst_q; // Reset synchroniser in the output domain.
	logic linkRunN; // Output domain out of reset.
	logic [2:0] linkTog_q; // Burst toggle synchroniser.
	logic linkSeen_q; // Last toggle value taken.
	logic linkLoad; // New burst arrived in the output domain.
	logic [dbs_pkg::WORD_W-1:0] scData, lkData; // Data from each domain.
	logic scOe, lkOe, scEchoR, scEchoF, lkEchoR, lkEchoF;

	assign inWord = '{laneWrEn: ~laneWriteEnableN, data: writeBusIn};

	// ********************************************************************
	// Edge phase and arbitration.
	// ********************************************************************

	// The first edge after reset is a rising input-clock edge; edges alternate.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			kEdge_q <= 1'b1;
		end else if (clkEn) begin
			kEdge_q <= ~kEdge_q;
		end
	end

	// Selects count only on rising edges. A port that started last time is
	// refused, and when both ask the one that did not just start wins.
	always_comb begin
		startRead = kEdge_q && !readPortSelectN && (lastStart_q != dbs_pkg::DBS_READ);
		startWrite = kEdge_q && !writePortSelectN
			&& (lastStart_q != dbs_pkg::DBS_WRITE) && !startRead;
	end

	// Remember what started at each rising edge for the next arbitration.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lastStart_q <= dbs_pkg::DBS_IDLE;
		end else if (clkEn && kEdge_q) begin
			case ({startRead, startWrite})
				2'h2: begin
					lastStart_q <= dbs_pkg::DBS_READ;
				end
				2'h1: begin
					lastStart_q <= dbs_pkg::DBS_WRITE;
				end
				default: begin
					lastStart_q <= dbs_pkg::DBS_IDLE;
				end
			endcase
		end
	end

	// ********************************************************************
	// Read port.
	// ********************************************************************

	// Read address is latched at the start; the burst is handed out four edges
	// later, which lines up with the commit of a write started just before.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdCnt_q <= 3'h0;
		end else if (clkEn) begin
			if (startRead) begin
				rdCnt_q <= 3'h1;
				rdAddr_q <= address;
			end else if (rdCnt_q != 3'h0) begin
				// A restart on the hand-over edge keeps reads pipelined.
				rdCnt_q <= (rdCnt_q == dbs_pkg::RD_HAND_CNT) ? 3'h0 : rdCnt_q + 3'h1;
			end
		end
	end

	assign rdHand = (rdCnt_q == dbs_pkg::RD_HAND_CNT);

	// Words come from the array, overlaid by the burst committing on the same
	// edge, so a read right behind a write to the same place sees new data.
	always_comb begin
		rdMerged = '0;
		for (int i = 0; i < dbs_pkg::BURST; i++) begin
			rdMerged[i] = mem[wordAddr(rdAddr_q, i)];
			for (int j = 0; j < dbs_pkg::BURST; j++) begin
				if (wrCommit_q && (wordAddr(colAddr_q, j) == wordAddr(rdAddr_q, i))) begin
					for (int l = 0; l < dbs_pkg::LANES; l++) begin
						if (wrBuf_q[j].laneWrEn[l]) begin
							rdMerged[i][l*LW +: LW] = wrBuf_q[j].data[l*LW +: LW];
						end
					end
				end
			end
		end
	end

	// Hand the burst across: data and the toggle that announces it change on the same edge.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xTog_q <= 1'b0;
		end else if (clkEn && rdHand) begin
			xBurst_q <= rdMerged;
			xTog_q <= ~xTog_q;
		end
	end

	// ********************************************************************
	// Write port.
	// ********************************************************************

	// An accepted write waits for the next rising edge before its first word.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wrArm1_q <= 1'b0;
			wrArm2_q <= 1'b0;
		end else if (clkEn) begin
			wrArm1_q <= startWrite;
			wrArm2_q <= wrArm1_q;
			if (startWrite) begin
				wrPendAddr_q <= address;
			end
		end
	end

	// Four words on successive edges; outside a burst the pins are ignored.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			colCnt_q <= 2'h0;
			wrCommit_q <= 1'b0;
		end else if (clkEn) begin
			wrCommit_q <= 1'b0;
			if (wrArm2_q) begin
				colAddr_q <= wrPendAddr_q;
				wrBuf_q[0] <= inWord;
				colCnt_q <= 2'h1;
			end else if (colCnt_q != 2'h0) begin
				wrBuf_q[colCnt_q] <= inWord;
				colCnt_q <= colCnt_q + 2'h1;
				wrCommit_q <= (colCnt_q == 2'h3);
			end
			// With no arm and no burst in progress nothing is sampled.
		end
	end

	// All 72 bits land at once; a disabled lane leaves its cell untouched.
	always_ff @(posedge clk) begin
		if (reset_n && clkEn && wrCommit_q) begin
			for (int i = 0; i < dbs_pkg::BURST; i++) begin
				for (int l = 0; l < dbs_pkg::LANES; l++) begin
					if (wrBuf_q[i].laneWrEn[l]) begin
						mem[wordAddr(colAddr_q, i)][l*LW +: LW] <= wrBuf_q[i].data[l*LW +: LW];
					end
				end
			end
		end
	end

	// ********************************************************************
	// Clock mode strap, delay-lock loop and impedance cadence.
	// ********************************************************************

	// Pin synchronisers: three stages; loop and impedance values used once stages two and three agree, the strap only when both are high.
	always_ff @(posedge clk) begin
		if (clkEn) begin
			strapSync_q <= {strapSync_q[1:0], outClockRiseLevel, outClockFallLevel};
			dOffSync_q <= {dOffSync_q[1:0], dllOffN};
			impSync_q <= {impSync_q[1:0], impedanceRefPin};
		end
	end

	// The strap is taken once on the first edge after reset and then frozen.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strapDone_q <= 1'b0;
			singleClockMode <= 1'b0;
		end else if (clkEn && !strapDone_q) begin
			strapDone_q <= 1'b1;
			singleClockMode <= (&strapSync_q[1]) && (&strapSync_q[2]);
		end
	end

	// A low clock enable stands for the input clock being stopped; this one
	// counter keeps running then, because it must see the stop.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stopCnt_q <= '0;
			lockCnt_q <= '0;
			dllLocked <= 1'b0;
			dllOn_q <= 1'b0;
		end else if (!clkEn) begin
			if (stopCnt_q >= dbs_pkg::DLL_STOP_LAST) begin
				lockCnt_q <= '0;
				dllLocked <= 1'b0;
			end else begin
				stopCnt_q <= stopCnt_q + dbs_pkg::CNT_W'(1);
			end
		end else begin
			stopCnt_q <= '0;
			if (dOffSync_q[1] == dOffSync_q[2]) begin
				dllOn_q <= dOffSync_q[2];
			end
			if (!dllOn_q || (dOffSync_q[1] == dOffSync_q[2] && !dOffSync_q[2])) begin
				lockCnt_q <= '0;
				dllLocked <= 1'b0;
			end else if (lockCnt_q == dbs_pkg::DLL_LOCK_LAST) begin
				dllLocked <= 1'b1;
			end else begin
				lockCnt_q <= lockCnt_q + dbs_pkg::CNT_W'(1);
			end
		end
	end

	// The code is slow-moving, so a disagreeing sample simply keeps the old one.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			impCnt_q <= '0;
			impedanceUpdate <= 1'b0;
			impedanceCode <= dbs_pkg::IMP_RESET;
		end else if (clkEn) begin
			impCnt_q <= (impCnt_q == dbs_pkg::IMP_LAST) ? '0 : impCnt_q + dbs_pkg::CNT_W'(1);
			impedanceUpdate <= (impCnt_q == dbs_pkg::IMP_LAST);
			if ((impCnt_q == dbs_pkg::IMP_LAST) && (impSync_q[1] == impSync_q[2])) begin
				impedanceCode <= impSync_q[2];
			end
		end
	end

	// ********************************************************************
	// Output clock domain.
	// ********************************************************************

	// Reset and burst toggle cross in on three flops each.
	always_ff @(posedge outStrobeClk) begin
		linkRst_q <= {linkRst_q[1:0], reset_n};
		linkTog_q <= {linkTog_q[1:0], xTog_q};
	end

	assign linkRunN = linkRst_q[1] & linkRst_q[2];
	assign linkLoad = (linkTog_q[1] == linkTog_q[2]) && (linkTog_q[2] != linkSeen_q);

	// A burst is taken once; the held data stays still long after the toggle.
	always_ff @(posedge outStrobeClk) begin
		if (!linkRunN) begin
			linkSeen_q <= 1'b0;
		end else if (linkLoad) begin
			linkSeen_q <= linkTog_q[2];
		end
	end

	dbs_out_shifter linkShift (
		.clk(outStrobeClk),
		.runN(linkRunN),
		.en(1'b1),
		.load(linkLoad),
		.burst(xBurst_q),
		.dataOut(lkData),
		.dataOe(lkOe),
		.echoRise(lkEchoR),
		.echoFall(lkEchoF)
	);

	// In single-clock mode the same shifter runs on the input clock instead.
	dbs_out_shifter coreShift (
		.clk(clk),
		.runN(reset_n),
		.en(clkEn),
		.load(rdHand),
		.burst(rdMerged),
		.dataOut(scData),
		.dataOe(scOe),
		.echoRise(scEchoR),
		.echoFall(scEchoF)
	);

	// The mode is a strap, so this choice never switches during traffic.
	always_comb begin
		readBusOut = singleClockMode ? scData : lkData;
		readBusOe = singleClockMode ? scOe : lkOe;
		echoStrobeRise = singleClockMode ? scEchoR : lkEchoR;
		echoStrobeFall = singleClockMode ? scEchoF : lkEchoF;
	end

	// ********************************************************************
	// Checks.
	// ********************************************************************
	a_read_first_arb: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		(kEdge_q && !readPortSelectN && !writePortSelectN && lastStart_q == dbs_pkg::DBS_READ)
		|=> lastStart_q == dbs_pkg::DBS_WRITE) else $error("write did not win after read");
	a_alt_start: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		(kEdge_q && lastStart_q == dbs_pkg::DBS_IDLE && !readPortSelectN && !writePortSelectN)
		|=> lastStart_q == dbs_pkg::DBS_READ) else $error("idle start not a read");
	a_no_back_read: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		startRead |-> ##2 !startRead) else $error("back-to-back read accepted");
	a_no_back_write: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		startWrite |-> ##2 !startWrite) else $error("back-to-back write accepted");
	a_sel_rise_only: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		!kEdge_q |-> !startRead && !startWrite) else $error("select taken on fall edge");
	a_read_handoff: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		startRead |-> ##4 rdHand) else $error("read burst hand-over late");
	a_write_commit: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		startWrite |-> ##5 !wrCommit_q ##1 wrCommit_q) else $error("write commit off time");
	a_dll_lock: assert property (@(posedge clk) disable iff (!reset_n)
		dllLocked |-> dllOn_q && lockCnt_q == dbs_pkg::DLL_LOCK_LAST) else $error("early lock");
	a_imp_cadence: assert property (@(posedge clk) disable iff (!reset_n || !clkEn)
		impedanceUpdate |-> impCnt_q == '0 ##1 !impedanceUpdate) else $error("impedance cadence");
	a_dll_stop: assert property (@(posedge clk) disable iff (!reset_n)
		(!clkEn && stopCnt_q >= dbs_pkg::DLL_STOP_LAST) |=> !dllLocked) else $error("lock kept");

	c_read_burst: cover property (@(posedge clk) disable iff (!reset_n) startRead ##4 rdHand);
	c_write_commit: cover property (@(posedge clk) disable iff (!reset_n) wrCommit_q && clkEn);
	c_forward: cover property (@(posedge clk) disable iff (!reset_n)
		rdHand && wrCommit_q && colAddr_q == rdAddr_q);
	c_both_sel: cover property (@(posedge clk) disable iff (!reset_n)
		kEdge_q && !readPortSelectN && !writePortSelectN);
endmodule

// ==== rtl/dbs_pkg.sv ====
// Summary of operation
// - Selects and lane enables registered on input edges.
// - Read starts on select low, address captured.
// - Every access moves four 18-bit words.
// - Read words leave one per output edge.
// - Back-to-back read request is ignored.
// - Alternate-edge reads pipeline into continuous output.
// - Finish reads, then release bus after edge.
// - Write starts on select low, address captured.
// - Collect four write words, then commit together.
// - Back-to-back write request is discarded.
// - Deselected write port ignores inputs after burst.
// - Disabled lanes keep stored contents per word.
// - Output clock pins high at reset: single clock.
// - Read after write returns newest data.
// - Both selected: arbitrate on previous start.
// - Both held selected: alternate, read first.
// - Port selects sampled on rising input edges only.
// - Deselecting one port never disturbs the other.
// - Impedance re-evaluated every 1024 cycles.
// - Two free-running echo clocks follow output clocks.
// - Lock reported after 1024 stable cycles, DLL on.
// - Stopped input clock resets delay-lock loop.
// - Deselected with bus released after power up.
// - Burst walks base address upward by one.
package dbs_pkg;
	// ********************************************************************
	// Geometry of the array and the burst.
	// ********************************************************************
	localparam int WORD_W = 18; // One burst word.
	localparam int LANES = 2; // Independently writable lanes per word.
	localparam int LANE_W = 9; // Bits per lane.
	localparam int BURST = 4; // Words per access.
	localparam int ADDR_W = 21; // Word address width.
	localparam int DEPTH = 1 << ADDR_W; // Words in the array.
	localparam int IMP_W = 5; // Width of the impedance code.
	localparam int CNT_W = 12; // Width of the housekeeping counters.

	// ********************************************************************
	// Timing, counted in clk edges; each input clock cycle has two edges.
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 40; // Period of clk.
	localparam int EDGES_PER_KCYCLE = 2; // Rise edge, then fall-strobe edge.
	localparam logic [2:0] RD_HAND_CNT = 3'h4; // Edges from read start to hand-over.
	localparam int IMP_KCYCLES = 1024; // Impedance update period.
	localparam int IMP_CYC = IMP_KCYCLES * EDGES_PER_KCYCLE;
	localparam logic [CNT_W-1:0] IMP_LAST = CNT_W'(IMP_CYC - 1);
	localparam int DLL_LOCK_KCYCLES = 1024; // Stable cycles before lock.
	localparam int DLL_LOCK_CYC = DLL_LOCK_KCYCLES * EDGES_PER_KCYCLE;
	localparam logic [CNT_W-1:0] DLL_LOCK_LAST = CNT_W'(DLL_LOCK_CYC - 1);
	localparam int DLL_STOP_NS = 30; // Least stop that resets the loop.
	localparam int DLL_STOP_CYC_RAW = (DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLL_STOP_CYC = (DLL_STOP_CYC_RAW < 1) ? 1 : DLL_STOP_CYC_RAW;
	localparam logic [CNT_W-1:0] DLL_STOP_LAST = CNT_W'(DLL_STOP_CYC - 1);

	// ********************************************************************
	// Reset values.
	// ********************************************************************
	localparam logic [WORD_W-1:0] OUT_RESET = 18'h00000; // Read bus value from reset until the first burst.
	localparam logic [IMP_W-1:0] IMP_RESET = 5'h00; // Code before first update.

	// Which port started on the previous rising input edge (Gray along the path).
	typedef enum logic [1:0] {
		DBS_IDLE = 2'h0,
		DBS_READ = 2'h1,
		DBS_WRITE = 2'h3
	} dbs_start_type;

	// One collected write word with its active-high lane enables.
	typedef struct packed {
		logic [LANES-1:0] laneWrEn;
		logic [WORD_W-1:0] data;
	} dbs_lane_word_type;

	// A whole read burst, word 0 in the low slot.
	typedef logic [BURST-1:0][WORD_W-1:0] dbs_burst_type;
endpackage

// ==== rtl/dbs_out_shifter.sv ====
`timescale 1ns/1ps
// ************************************************************************
// Read burst shifter with bus release and echo clock pair.
// ************************************************************************
module dbs_out_shifter (
	input logic clk,
	input logic runN,
	input logic en,
	input logic load,
	input dbs_pkg::dbs_burst_type burst,
	output logic [dbs_pkg::WORD_W-1:0] dataOut,
	output logic dataOe,
	output logic echoRise,
	output logic echoFall
);
	dbs_pkg::dbs_burst_type burst_q; // Burst being sent.
	logic [1:0] idx_q; // Next word to send.
	logic busy_q; // Words of the burst remain.

	// Word 0 leaves on the load edge; a load on the edge after the last word
	// keeps the bus driven, so alternate-edge reads stream without gaps.
	always_ff @(posedge clk) begin
		if (!runN) begin
			dataOut <= dbs_pkg::OUT_RESET;
			dataOe <= 1'b0;
			busy_q <= 1'b0;
			idx_q <= 2'h0;
		end else if (en) begin
			if (load) begin
				burst_q <= burst;
				dataOut <= burst[0];
				dataOe <= 1'b1;
				idx_q <= 2'h1;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				dataOut <= burst_q[idx_q];
				idx_q <= idx_q + 2'h1;
				busy_q <= (idx_q != 2'h3);
			end else begin
				// Bus is released one edge after the last word.
				dataOe <= 1'b0;
			end
		end
	end

	// Echo pair toggles on every edge whether or not data moves.
	always_ff @(posedge clk) begin
		if (!runN) begin
			echoRise <= 1'b0;
			echoFall <= 1'b1;
		end else if (en) begin
			echoRise <= ~echoRise;
			echoFall <= echoRise;
		end
	end

	// Antecedents demand enable as sampled, and the echo check also run, so an edge at which
	// the enable, or for the echo check reset, changes by a late assignment does not start a check against frozen state.
	a_oe_release: assert property (@(posedge clk) disable iff (!runN || !en)
		(en && !busy_q && !load) |=> !dataOe) else $error("bus not released");
	a_echo_toggle: assert property (@(posedge clk) disable iff (!runN || !en)
		(runN && en) |=> (echoRise != $past(echoRise)) && (echoFall != echoRise))
		else $error("echo pair stalled");
endmodule

// ==== verification/dbs_ctrl_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Controller model: requests on rise-strobe edges, words on every edge.
// ****************************************
module dbs_ctrl_model (
	input logic clk,
	input logic reset_n,
	input logic clkEn,
	output logic readPortSelectN,
	output logic writePortSelectN,
	output logic [20:0] address,
	output logic [17:0] writeBusIn,
	output logic [1:0] laneWriteEnableN
);
	// High when the coming clk edge is a fall-strobe edge.
	logic fallNext_q = 1'b0;

	// Idle pins at time zero.
	initial begin
		readPortSelectN = 1'b1;
		writePortSelectN = 1'b1;
		address = 21'h000000;
		writeBusIn = 18'h00000;
		laneWriteEnableN = 2'h3;
	end

	// The phase freezes with the device while the input clock is stopped.
	always @(posedge clk) begin
		if (!reset_n)
			fallNext_q <= 1'b0;
		else if (clkEn)
			fallNext_q <= ~fallNext_q;
	end

	// One request on the next rise-strobe edge, then release with a changed address.
	task automatic issue(input logic rdN, input logic wrN, input logic [20:0] a);
		do @(posedge clk); while (fallNext_q !== 1'b1);
		readPortSelectN <= rdN;
		writePortSelectN <= wrN;
		address <= a;
		@(posedge clk);
		readPortSelectN <= 1'b1;
		writePortSelectN <= 1'b1;
		address <= ~a;
	endtask

	// Four words from the second edge after the request; enN packs two bits a word.
	task automatic sendWords(input dbs_pkg::dbs_burst_type w, input logic [7:0] enN);
		@(posedge clk);
		for (int k = 0; k < 4; k++) begin
			writeBusIn <= w[k];
			laneWriteEnableN <= enN[2*k +: 2];
			@(posedge clk);
		end
		// Released lines never keep the last value, so a stale sample shows up.
		writeBusIn <= ~w[3];
		laneWriteEnableN <= ~enN[7:6];
	endtask
endmodule

// ==== verification/dbs_burst_sram_test.sv ====
`timescale 1ns/1ps
module dbs_burst_sram_test;
	logic clk = 1'b0;
	logic osClk = 1'b0; // Output clock, unrelated in phase.
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic dllOffN = 1'b1;
	logic strap = 1'b1; // Both output clock pin levels, moved together.
	logic rdN, wrN, oe, eR, eF, scm, lock, upd, e;
	logic [20:0] addr;
	logic [17:0] wd, rd;
	logic [1:0] lnN;
	logic [4:0] imp;
	int errors = 0;
	int samples_checked = 0;
	dbs_pkg::dbs_burst_type q, q2, m;
	dbs_pkg::dbs_burst_type d = {18'h3C0F0, 18'h2A55A, 18'h15AA5, 18'h0FF00};
	logic [20:0] ra = 21'h1FFFFE; // The burst wraps past the top address.
	logic [20:0] rb = 21'h000100;

	always #20 clk = ~clk;
	initial begin
		#13;
		forever #80 osClk = ~osClk;
	end

	dbs_burst_sram dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .outStrobeClk(osClk),
		.readPortSelectN(rdN), .writePortSelectN(wrN), .address(addr), .writeBusIn(wd),
		.laneWriteEnableN(lnN), .outClockRiseLevel(strap), .outClockFallLevel(strap),
		.dllOffN(dllOffN), .impedanceRefPin(5'h15), .readBusOut(rd), .readBusOe(oe),
		.echoStrobeRise(eR), .echoStrobeFall(eF), .singleClockMode(scm),
		.dllLocked(lock), .impedanceCode(imp), .impedanceUpdate(upd));
	dbs_ctrl_model ctrl (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
		.readPortSelectN(rdN), .writePortSelectN(wrN), .address(addr),
		.writeBusIn(wd), .laneWriteEnableN(lnN));

	// ****************************************
	// Compare and capture helpers.
	// ****************************************
	task automatic chkW(input logic [17:0] got, input logic [17:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkB(input logic got, input logic exp);
		chkW({17'h0, got}, {17'h0, exp});
	endtask
	task automatic chkQ(input dbs_pkg::dbs_burst_type g, input dbs_pkg::dbs_burst_type x);
		for (int i = 0; i < 4; i++)
			chkW(g[i], x[i]);
	endtask
	// Four words one edge apart, sampled once settled; optionally the release edge.
	task automatic rx(input int pre, input bit endChk, output dbs_pkg::dbs_burst_type g);
		repeat (pre) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			@(negedge clk);
			chkB(oe, 1'b1);
			g[i] = rd;
		end
		if (endChk) begin
			@(posedge clk);
			@(negedge clk);
			chkB(oe, 1'b0);
		end
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	// A read two edges behind a write to the same place sees the new words.
	task automatic t_fwd;
		ctrl.issue(1'b1, 1'b0, ra);
		fork
			ctrl.sendWords(d, 8'h00);
			begin
				ctrl.issue(1'b0, 1'b1, ra);
				rx(3, 1'b1, q);
			end
		join
		chkQ(q, d);
		ctrl.issue(1'b0, 1'b1, ra);
		rx(3, 1'b1, q);
		chkQ(q, d);
	endtask
	// Lane enables differ per word; disabled lanes keep the old contents.
	task automatic t_lanes;
		for (int k = 0; k < 4; k++) begin
			m[k][8:0] = (8'h39 >> (2*k)) & 1 ? d[k][8:0] : ~d[k][8:0];
			m[k][17:9] = (8'h39 >> (2*k+1)) & 1 ? d[k][17:9] : ~d[k][17:9];
		end
		ctrl.issue(1'b1, 1'b0, ra);
		ctrl.sendWords(~d, 8'h39);
		ctrl.issue(1'b0, 1'b1, ra);
		rx(3, 1'b1, q);
		chkQ(q, m);
	endtask
	// Both selects held from idle: read first, then the write.
	task automatic t_arb;
		ctrl.issue(1'b0, 1'b0, ra);
		fork
			begin
				ctrl.issue(1'b0, 1'b0, rb);
				ctrl.sendWords(d, 8'h00);
			end
			rx(3, 1'b1, q);
		join
		chkQ(q, m);
		ctrl.issue(1'b0, 1'b1, rb);
		rx(3, 1'b1, q);
		chkQ(q, d);
	endtask
	// A read on the very next rise-strobe edge is ignored.
	task automatic t_refuse;
		ctrl.issue(1'b0, 1'b1, ra);
		fork
			ctrl.issue(1'b0, 1'b1, rb);
			rx(3, 1'b1, q);
		join
		chkQ(q, m);
	endtask
	// Reads every other rise-strobe edge leave the bus busy without a gap.
	task automatic t_pipe;
		ctrl.issue(1'b0, 1'b1, ra);
		ctrl.issue(1'b1, 1'b1, ra);
		fork
			ctrl.issue(1'b0, 1'b1, rb);
			rx(1, 1'b0, q);
		join
		rx(0, 1'b1, q2);
		chkQ(q, m);
		chkQ(q2, d);
	endtask
	// Stopped clock relocks after the lock count; impedance update spacing.
	task automatic t_house;
		int n;
		n = 0;
		while (lock !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chkB(lock, 1'b1);
		@(posedge clk) clkEn <= 1'b0;
		@(posedge clk) clkEn <= 1'b1;
		@(negedge clk);
		chkB(lock, 1'b0);
		n = 1;
		while (lock !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chkB(n >= 2044 && n <= 2052, 1'b1);
		n = 0;
		while (upd !== 1'b1 && n < 2100) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (upd !== 1'b1 && n < 2100);
		chkW(18'(n), 18'h00800);
		chkW({13'h0, imp}, 18'h00015);
		@(posedge clk) dllOffN <= 1'b0;
		repeat (5) @(negedge clk);
		chkB(lock, 1'b0);
	endtask
	// Output clock pins low through a second reset: the burst leaves on osClk.
	task automatic t_dual;
		@(posedge clk) reset_n <= 1'b0;
		strap <= 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (16) @(negedge clk);
		chkB(scm, 1'b0);
		chkB(oe, 1'b0);
		ctrl.issue(1'b0, 1'b1, rb);
		@(posedge oe);
		for (int i = 0; i < 4; i++) begin
			@(negedge osClk);
			q[i] = rd;
		end
		@(negedge osClk);
		chkB(oe, 1'b0);
		chkQ(q, d);
	endtask

	// Verdict and end of run.
	task automatic stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hang is cut off well past the longest expected run.
	initial begin
		#(12000 * 40);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		stop_test;
	end

	// Main sequence.
	initial begin
		repeat (15) @(posedge clk);
		@(negedge clk);
		chkB(oe, 1'b0);
		@(posedge clk) reset_n <= 1'b1;
		repeat (2) @(negedge clk);
		chkB(scm, 1'b1);
		chkB(oe, 1'b0);
		repeat (3) begin
			e = eR;
			@(negedge clk);
			chkB(eR, ~e);
			chkB(eF, ~eR);
		end
		t_fwd;
		t_lanes;
		t_arb;
		t_refuse;
		t_pipe;
		t_house;
		t_dual;
		stop_test;
	end
endmodule
